// >>> src/e1_ovh_pkg.sv
// Constants, register map and carrier types for the E1 transmit overhead selector.
//
// What this block does
// - CRC-4 select 0: framer computes CRC-4 bits and inserts them itself.
// - CRC-4 select 1: CRC-4 bits are copied unchanged from the serial input.
// - CRC-4 select is ignored while CRC multiframe alignment is disabled.
// - Alignment select 0: FAS, multiframe and A bits generated internally; E bits follow the E-bit source field.
// - Alignment select 1: FAS, multiframe, E and A bits taken from serial input.
// - E-bit source field, bits 7-6, acts only while alignment is internal.
// - National enables for bits 8..4 sit at bits 7..3, same timeslot-0 position.
// - Enable 0 with serial source forces that national bit to one.
// - Enable 1 lets that national bit carry data link traffic.
// - Per-bit select inserts each national bit from serial input or register.
// - Data link uses a bit only if link source is 01 and select is serial.
// - Link source code 01 selects the transmit HDLC controller as data source.
package e1_ovh_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0] SYNC_MUX_IDX = 10'h109;
  localparam logic [9:0] TX_SIG_DL_IDX = 10'h10a;
  localparam logic [9:0] FRAMING_CTRL_IDX = 10'h10b;
  localparam logic [9:0] STATUS_IDX = 10'h10c;
  localparam logic [9:0] NAT_SELECT_IDX = 10'h130;
  localparam logic [9:0] NAT_VALUE_IDX = 10'h131;

  // Reset values
  localparam logic [7:0] SYNC_MUX_RST = 8'h00;
  localparam logic [7:0] TX_SIG_DL_RST = 8'h00;
  localparam logic [7:0] FRAMING_CTRL_RST = 8'h01;
  localparam logic [7:0] NAT_SELECT_RST = 8'h00;
  localparam logic [7:0] NAT_VALUE_RST = 8'hf8;

  // Field positions
  localparam int ALIGN_SRC_BIT = 0;
  localparam int CRC_SRC_BIT = 1;
  localparam int DL_SRC_LSB = 2;
  localparam int EBIT_SRC_LSB = 6;
  localparam int CRC_MF_EN_BIT = 0;
  localparam int NAT_LO_BIT = 3;
  localparam int NAT_HI_BIT = 7;

  // Source codes
  localparam logic [1:0] DL_SRC_HDLC = 2'h1;
  localparam logic [1:0] EBIT_SRC_SERIAL = 2'h1;

  // ----------------------------------------------------------------
  // Frame timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int BIT_PERIOD_NS = 488;
  localparam int BIT_DIV = (BIT_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] BIT_DIV_LAST = 3'(BIT_DIV - 1);
  localparam logic [7:0] LAST_BIT_POS = 8'hff;
  localparam logic [3:0] LAST_FRAME = 4'hf;
  localparam logic [3:0] FIRST_EBIT_FRAME = 4'hc;
  localparam logic [7:0] FAS_WORD = 8'h1b;
  localparam logic [5:0] MFAS_WORD = 6'h0b;
  localparam logic [1:0] BUF_DEPTH = 2'h2;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic data;        // Outbound line bit
    logic frame_start; // First bit of a frame
    logic mf_start;    // First bit of a multiframe
  } line_word_t;

  typedef struct packed {
    logic [7:0] sync_mux;
    logic [7:0] tx_sig_dl;
    logic [7:0] framing_ctrl;
    logic [7:0] nat_select;
    logic [7:0] nat_value;
  } regs_t;

  typedef struct packed {
    regs_t regs;
    logic [31:0] prdata;
    logic ser_meta;
    logic ser_sync;
    logic [2:0] div_cnt;
    logic tick_pend;
    logic [7:0] bit_pos;
    logic [3:0] frame_num;
    logic [3:0] crc;
    logic [3:0] crc_hold;
    line_word_t word0;
    line_word_t word1;
    logic [1:0] count;
  } state_t;

endpackage

// >>> src/e1_tx_overhead_source_select.sv
// E1 transmit overhead source selector with APB registers and a two-entry output buffer.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module e1_tx_overhead_source_select (
  input wire logic pclk,                  // 10 MHz system clock
  input wire logic presetn,               // Async reset, active low
  input wire logic psel,                  // APB select
  input wire logic penable,               // APB access phase
  input wire logic pwrite,                // APB direction
  input wire logic [11:0] paddr,          // APB byte address
  input wire logic [31:0] pwdata,         // APB write data
  input wire logic [3:0] pstrb,           // APB byte strobes
  output logic [31:0] prdata,             // APB read data
  output logic pready,                    // APB ready
  output logic pslverr,                   // APB error on unmapped address
  input wire logic tx_serial_in,          // Serial input from terminal
  output logic [7:0] tx_bit_pos,          // Bit position now being framed
  output logic [3:0] tx_frame_num,        // Frame number in multiframe
  input wire logic hdlc_bit,              // Next data link bit from HDLC
  output logic hdlc_take,                 // HDLC bit consumed this cycle
  output logic out_valid,                 // Line word available
  input wire logic out_ready,             // Receiver accepts line word
  output e1_ovh_pkg::line_word_t out_word // Line word
);

  // ----------------------------------------------------------------
  // State and decode helpers
  // ----------------------------------------------------------------
  e1_ovh_pkg::state_t state;
  e1_ovh_pkg::state_t next_state;
  logic push;
  logic pop;
  logic comp_bit;
  logic is_nat;
  logic crc_ext;
  logic align_ext;
  logic crc_mf;
  logic [1:0] dl_src;
  logic [1:0] ebit_src;

  // Register hit for a word-aligned address
  function automatic logic hit(input logic [11:0] addr, input logic [9:0] idx);
    hit = (addr[11:2] == idx) && (addr[1:0] == 2'h0);
  endfunction

  // Any mapped register
  function automatic logic mapped(input logic [11:0] addr);
    mapped = hit(addr, e1_ovh_pkg::SYNC_MUX_IDX) || hit(addr, e1_ovh_pkg::TX_SIG_DL_IDX)
      || hit(addr, e1_ovh_pkg::FRAMING_CTRL_IDX) || hit(addr, e1_ovh_pkg::STATUS_IDX)
      || hit(addr, e1_ovh_pkg::NAT_SELECT_IDX) || hit(addr, e1_ovh_pkg::NAT_VALUE_IDX);
  endfunction

  // Field views of the control registers
  assign align_ext = state.regs.sync_mux[e1_ovh_pkg::ALIGN_SRC_BIT];
  assign crc_ext = state.regs.sync_mux[e1_ovh_pkg::CRC_SRC_BIT];
  assign dl_src = state.regs.sync_mux[e1_ovh_pkg::DL_SRC_LSB +: 2];
  assign ebit_src = state.regs.sync_mux[e1_ovh_pkg::EBIT_SRC_LSB +: 2];
  assign crc_mf = state.regs.framing_ctrl[e1_ovh_pkg::CRC_MF_EN_BIT];

  // ----------------------------------------------------------------
  // Line bit composition
  // ----------------------------------------------------------------
  // Serial sample is the synchronised pin; payload always follows it
  always_comb begin
    comp_bit = state.ser_sync;
    is_nat = 1'b0;
    if (state.bit_pos < 8'h08) begin
      if (!state.frame_num[0]) begin
        if (state.bit_pos == 8'h00) begin
          if (crc_mf) begin
            // Select bit only matters in multiframe mode
            comp_bit = crc_ext ? state.ser_sync
              : state.crc_hold[2'h3 - state.frame_num[2:1]];
          end else begin
            comp_bit = align_ext ? state.ser_sync : 1'b1;
          end
        end else begin
          comp_bit = align_ext ? state.ser_sync
            : e1_ovh_pkg::FAS_WORD[3'h7 - state.bit_pos[2:0]];
        end
      end else begin
        unique case (state.bit_pos[2:0])
          3'h0: begin
            if (align_ext || !crc_mf) begin
              comp_bit = align_ext ? state.ser_sync : 1'b1;
            end else if (state.frame_num >= e1_ovh_pkg::FIRST_EBIT_FRAME) begin
              // E-bit source field only consulted when generated internally
              comp_bit = (ebit_src == e1_ovh_pkg::EBIT_SRC_SERIAL) ? state.ser_sync
                : 1'b1;
            end else begin
              comp_bit = e1_ovh_pkg::MFAS_WORD[3'h5 - state.frame_num[3:1]];
            end
          end
          3'h1: comp_bit = align_ext ? state.ser_sync : 1'b1;
          3'h2: comp_bit = align_ext ? state.ser_sync : 1'b0;
          default: begin
            // National bits, enable and select share the bit index
            is_nat = 1'b1;
            if (state.regs.nat_select[state.bit_pos[2:0]]) begin
              comp_bit = state.regs.nat_value[state.bit_pos[2:0]];
            end else if (!state.regs.tx_sig_dl[state.bit_pos[2:0]]) begin
              comp_bit = 1'b1;
            end else if (dl_src == e1_ovh_pkg::DL_SRC_HDLC) begin
              comp_bit = hdlc_bit;
            end else begin
              comp_bit = state.ser_sync;
            end
          end
        endcase
      end
    end
  end

  // HDLC bit is consumed only when it actually reaches the line
  assign hdlc_take = push && is_nat && !state.regs.nat_select[state.bit_pos[2:0]]
    && state.regs.tx_sig_dl[state.bit_pos[2:0]] && (dl_src == e1_ovh_pkg::DL_SRC_HDLC);

  // ----------------------------------------------------------------
  // Buffer handshake
  // ----------------------------------------------------------------
  // A full buffer stalls the bit counter, so a slow receiver loses nothing
  assign pop = out_valid && out_ready;
  assign push = state.tick_pend && ((state.count < e1_ovh_pkg::BUF_DEPTH) || pop);
  assign out_valid = (state.count != 2'h0);
  assign out_word = state.word0;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    // Two-stage synchroniser for the serial pin
    next_state.ser_meta = tx_serial_in;
    next_state.ser_sync = state.ser_meta;

    // Bit-rate divider holds while a bit waits for buffer space
    if (!state.tick_pend) begin
      if (state.div_cnt == e1_ovh_pkg::BIT_DIV_LAST) begin
        next_state.div_cnt = 3'h0;
        next_state.tick_pend = 1'b1;
      end else begin
        next_state.div_cnt = state.div_cnt + 3'h1;
      end
    end

    // Buffer pop then push
    if (pop) begin
      next_state.word0 = state.word1;
    end
    if (push) begin
      next_state.tick_pend = 1'b0;
      if (next_state.count == 2'h0 || (pop && state.count == 2'h1)) begin
        next_state.word0 = '{comp_bit, state.bit_pos == 8'h00,
          (state.bit_pos == 8'h00) && (state.frame_num == 4'h0)};
      end else begin
        next_state.word1 = '{comp_bit, state.bit_pos == 8'h00,
          (state.bit_pos == 8'h00) && (state.frame_num == 4'h0)};
      end
    end
    next_state.count = state.count + {1'b0, push} - {1'b0, pop};

    // Frame counters and CRC over the sent bits, C-bit slots taken as zero
    if (push) begin
      next_state.bit_pos = state.bit_pos + 8'h01;
      next_state.crc = {state.crc[2:0], 1'b0}
        ^ ((state.crc[3] ^ (comp_bit && !(state.bit_pos == 8'h00 && !state.frame_num[0])))
        ? 4'h3 : 4'h0);
      if (state.bit_pos == e1_ovh_pkg::LAST_BIT_POS) begin
        next_state.frame_num = state.frame_num + 4'h1;
        if (state.frame_num[2:0] == 3'h7) begin
          // Remainder of one sub-multiframe goes into the next one
          next_state.crc_hold = next_state.crc;
          next_state.crc = 4'h0;
        end
      end
    end

    // APB read data captured in the setup phase, answered at access
    if (psel && !penable && !pwrite) begin
      next_state.prdata = 32'h0;
      if (hit(paddr, e1_ovh_pkg::SYNC_MUX_IDX)) begin
        next_state.prdata[7:0] = state.regs.sync_mux;
      end
      if (hit(paddr, e1_ovh_pkg::TX_SIG_DL_IDX)) begin
        next_state.prdata[7:0] = state.regs.tx_sig_dl;
      end
      if (hit(paddr, e1_ovh_pkg::FRAMING_CTRL_IDX)) begin
        next_state.prdata[7:0] = state.regs.framing_ctrl;
      end
      if (hit(paddr, e1_ovh_pkg::NAT_SELECT_IDX)) begin
        next_state.prdata[7:0] = state.regs.nat_select;
      end
      if (hit(paddr, e1_ovh_pkg::NAT_VALUE_IDX)) begin
        next_state.prdata[7:0] = state.regs.nat_value;
      end
      if (hit(paddr, e1_ovh_pkg::STATUS_IDX)) begin
        next_state.prdata[17:0] = {state.count, state.frame_num, state.crc_hold,
          state.bit_pos};
      end
    end

    // APB writes land on the access edge, low byte lane only
    if (psel && penable && pwrite && pstrb[0]) begin
      if (hit(paddr, e1_ovh_pkg::SYNC_MUX_IDX)) begin
        next_state.regs.sync_mux = pwdata[7:0];
      end
      if (hit(paddr, e1_ovh_pkg::TX_SIG_DL_IDX)) begin
        next_state.regs.tx_sig_dl = pwdata[7:0];
      end
      if (hit(paddr, e1_ovh_pkg::FRAMING_CTRL_IDX)) begin
        next_state.regs.framing_ctrl = {7'h00, pwdata[0]};
      end
      if (hit(paddr, e1_ovh_pkg::NAT_SELECT_IDX)) begin
        next_state.regs.nat_select = {pwdata[7:3], 3'h0};
      end
      if (hit(paddr, e1_ovh_pkg::NAT_VALUE_IDX)) begin
        next_state.regs.nat_value = {pwdata[7:3], 3'h0};
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= '0;
      state.regs.sync_mux <= e1_ovh_pkg::SYNC_MUX_RST;
      state.regs.tx_sig_dl <= e1_ovh_pkg::TX_SIG_DL_RST;
      state.regs.framing_ctrl <= e1_ovh_pkg::FRAMING_CTRL_RST;
      state.regs.nat_select <= e1_ovh_pkg::NAT_SELECT_RST;
      state.regs.nat_value <= e1_ovh_pkg::NAT_VALUE_RST;
    end else begin
      state <= next_state;
    end
  end

  // Outputs; zero wait state, so the bus never stalls
  assign prdata = state.prdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);
  assign tx_bit_pos = state.bit_pos;
  assign tx_frame_num = state.frame_num;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_crc_internal;
    @(posedge pclk) disable iff (!presetn)
    push && crc_mf && !crc_ext && !state.frame_num[0] && state.bit_pos == 8'h00
      |-> ##1 state.word0.data == $past(state.crc_hold[2'h3 - state.frame_num[2:1]])
        || state.count == 2'h2;
  endproperty
  a_crc_internal: assert property (p_crc_internal)
    else $error("internal CRC bit wrong");

  property p_crc_external;
    @(posedge pclk) disable iff (!presetn)
    push && crc_mf && crc_ext && !state.frame_num[0] && state.bit_pos == 8'h00
      |-> comp_bit == state.ser_sync;
  endproperty
  a_crc_external: assert property (p_crc_external)
    else $error("external CRC bit not copied");

  property p_crc_ignored;
    @(posedge pclk) disable iff (!presetn)
    push && !crc_mf && !align_ext && state.bit_pos == 8'h00 |-> comp_bit;
  endproperty
  a_crc_ignored: assert property (p_crc_ignored)
    else $error("CRC select used without multiframe");

  property p_fas_internal;
    @(posedge pclk) disable iff (!presetn)
    push && !align_ext && !state.frame_num[0] && state.bit_pos == 8'h01
      |-> !comp_bit ##1 (state.bit_pos == 8'h02);
  endproperty
  a_fas_internal: assert property (p_fas_internal)
    else $error("FAS pattern wrong");

  property p_align_external;
    @(posedge pclk) disable iff (!presetn)
    push && align_ext && state.bit_pos != 8'h00 && state.bit_pos < 8'h03
      |-> comp_bit == state.ser_sync;
  endproperty
  a_align_external: assert property (p_align_external)
    else $error("alignment bit not from serial input");

  property p_ebit_source;
    @(posedge pclk) disable iff (!presetn)
    push && state.frame_num[0] && state.bit_pos == 8'h00 && crc_mf && !align_ext
      && state.frame_num >= e1_ovh_pkg::FIRST_EBIT_FRAME && ebit_src != e1_ovh_pkg::EBIT_SRC_SERIAL
      |-> comp_bit;
  endproperty
  a_ebit_source: assert property (p_ebit_source)
    else $error("E bit not generated internally");

  property p_nat_forced;
    @(posedge pclk) disable iff (!presetn)
    push && is_nat && !state.regs.nat_select[state.bit_pos[2:0]]
      && !state.regs.tx_sig_dl[state.bit_pos[2:0]] |-> comp_bit && !hdlc_take;
  endproperty
  a_nat_forced: assert property (p_nat_forced)
    else $error("disabled national bit not forced high");

  property p_nat_datalink;
    @(posedge pclk) disable iff (!presetn)
    push && is_nat && state.regs.tx_sig_dl[state.bit_pos[2:0]]
      && !state.regs.nat_select[state.bit_pos[2:0]] && dl_src == e1_ovh_pkg::DL_SRC_HDLC
      |-> hdlc_take && comp_bit == hdlc_bit;
  endproperty
  a_nat_datalink: assert property (p_nat_datalink)
    else $error("data link bit not inserted");

  property p_nat_register;
    @(posedge pclk) disable iff (!presetn)
    push && is_nat && state.regs.nat_select[state.bit_pos[2:0]]
      |-> comp_bit == state.regs.nat_value[state.bit_pos[2:0]] && !hdlc_take;
  endproperty
  a_nat_register: assert property (p_nat_register)
    else $error("register national bit wrong");

  property p_buffer_hold;
    @(posedge pclk) disable iff (!presetn)
    out_valid && !out_ready |=> out_valid && $stable(out_word);
  endproperty
  a_buffer_hold: assert property (p_buffer_hold)
    else $error("buffered word lost under stall");

  // Only link source code 01 may draw bits from the HDLC side
  property p_link_source;
    @(posedge pclk) disable iff (!presetn)
    push && is_nat && dl_src != e1_ovh_pkg::DL_SRC_HDLC |-> !hdlc_take;
  endproperty
  a_link_source: assert property (p_link_source)
    else $error("data link bit taken from wrong source");

  // A full, stalled buffer freezes framing, so no bit is skipped
  property p_stall_hold;
    @(posedge pclk) disable iff (!presetn)
    state.count == 2'h2 && !out_ready |=> $stable(state.bit_pos) && state.count == 2'h2;
  endproperty
  a_stall_hold: assert property (p_stall_hold)
    else $error("framing advanced while buffer full");

endmodule // e1_tx_overhead_source_select

`default_nettype wire

// >>> verification/e1_terminal_model.sv
// Terminal equipment model driving the transmit serial pin.
`timescale 1ns/1ps
`default_nettype none

module e1_terminal_model (
  input wire logic [7:0] tx_bit_pos,   // Bit being framed next
  input wire logic [3:0] tx_frame_num, // Frame in multiframe
  output logic tx_serial_in            // Serial pin to the framer
);
  // Bit value follows the framed position, so a late or early sample shows up
  always_comb begin
    tx_serial_in = tx_bit_pos[0] ^ tx_bit_pos[2] ^ tx_bit_pos[4] ^ tx_frame_num[1];
  end
endmodule // e1_terminal_model

`default_nettype wire

// >>> verification/test_e1_tx_overhead_source_select.sv
// Self-checking bench for the E1 transmit overhead source selector.
`timescale 1ns/1ps
`default_nettype none

`define CHECK(nm, ex, gt) begin \
  n_compared++; \
  if ((gt) !== (ex)) begin \
    n_mismatch++; \
    $display("unexpected %s expected %h seen %h", nm, ex, gt); \
  end \
end

module test_e1_tx_overhead_source_select;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic tx_serial_in;
  logic [7:0] tx_bit_pos;
  logic [3:0] tx_frame_num;
  logic hdlc_bit = 1'b0;
  logic hdlc_take;
  logic out_valid;
  logic out_ready = 1'b1;
  e1_ovh_pkg::line_word_t out_word;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  int pos = 0;
  int frm = 0;
  int n_frames = 0;
  int n_take = 0;
  logic settle = 1'b0;
  logic cfg_busy = 1'b0;
  logic [7:0] m_smr = e1_ovh_pkg::SYNC_MUX_RST;
  logic [7:0] m_sdl = e1_ovh_pkg::TX_SIG_DL_RST;
  logic [7:0] m_fc = e1_ovh_pkg::FRAMING_CTRL_RST;
  logic [7:0] m_nsel = e1_ovh_pkg::NAT_SELECT_RST;
  logic [7:0] m_nval = e1_ovh_pkg::NAT_VALUE_RST;
  logic [3:0] m_crc = 4'h0;
  logic [3:0] m_hold = 4'h0;
  logic [31:0] rd;
  logic [31:0] st;
  logic err;

  // 10 MHz clock
  always #50 pclk = ~pclk;

  e1_tx_overhead_source_select dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_serial_in(tx_serial_in), .tx_bit_pos(tx_bit_pos),
    .tx_frame_num(tx_frame_num), .hdlc_bit(hdlc_bit), .hdlc_take(hdlc_take),
    .out_valid(out_valid), .out_ready(out_ready), .out_word(out_word)
  );

  e1_terminal_model term_u (
    .tx_bit_pos(tx_bit_pos), .tx_frame_num(tx_frame_num), .tx_serial_in(tx_serial_in)
  );

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr_en, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rdat, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= wd;
    pstrb <= 4'hf;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait states come from the slave; only the watchdog ends a hung wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] v);
    apb(1'b1, {idx, 2'b00}, {24'h0, v}, rd, err);
  endtask

  task automatic chk_reg(input logic [9:0] idx, input logic [7:0] v);
    apb(1'b0, {idx, 2'b00}, 32'h0, rd, err);
    `CHECK("register", {24'h0, v}, rd)
    `CHECK("pslverr", 1'b0, err)
  endtask

  // Mirror first, then write; checks pause until a clean frame boundary
  task automatic cfg(input logic [7:0] sync_mux_control, sdl, fc, nsel, nval);
    cfg_busy = 1'b1;
    settle = 1'b1;
    m_smr = sync_mux_control;
    m_sdl = sdl;
    m_fc = fc;
    m_nsel = nsel;
    m_nval = nval;
    wr(e1_ovh_pkg::SYNC_MUX_IDX, sync_mux_control);
    wr(e1_ovh_pkg::TX_SIG_DL_IDX, sdl);
    wr(e1_ovh_pkg::FRAMING_CTRL_IDX, fc);
    wr(e1_ovh_pkg::NAT_SELECT_IDX, nsel);
    wr(e1_ovh_pkg::NAT_VALUE_IDX, nval);
    repeat (20) @(posedge pclk);
    cfg_busy = 1'b0;
  endtask

  task automatic run_frames(input int n);
    int t;
    t = n_frames + n;
    while (n_frames < t) @(posedge pclk);
  endtask

  task automatic wrap_up();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Expected line bit: {checked, value}
  // ----------------------------------------------------------------
  function automatic logic [1:0] exp_bit(input int p, input int f);
    logic s;
    logic al;
    logic [7:0] fas;
    logic [5:0] mfas;
    logic [1:0] r;
    s = 1'(p ^ (p >> 2) ^ (p >> 4) ^ (f >> 1));
    al = m_smr[0];
    fas = 8'h1b;
    mfas = 6'h0b;
    r = 2'b00;
    if (p >= 8) r = {1'b1, s};
    else if (f % 2 == 0) begin
      if (p != 0) r = {1'b1, al ? s : fas[7-p]};
      else if (m_fc[0]) r = {1'b1, m_smr[1] ? s : m_hold[3 - (f % 8) / 2]};
      else r = {1'b1, al ? s : 1'b1};
    end else if (p == 0) begin
      if (al) r = {1'b1, s};
      else if (!m_fc[0]) r = 2'b11;
      else if (f < 12) r = {1'b1, mfas[5-(f-1)/2]};
      else r = {1'b1, (m_smr[7:6] == 2'h1) ? s : 1'b1};
    end
    else if (p == 1) r = {1'b1, al ? s : 1'b1};
    else if (p == 2) r = {1'b1, al ? s : 1'b0};
    else if (m_nsel[p]) r = {1'b1, m_nval[p]};
    else if (!m_sdl[p]) r = 2'b11;
    else if (m_smr[3:2] == 2'h1) r = {1'b1, hdlc_bit};
    else r = {1'b1, s};
    return r;
  endfunction

  // Line monitor and watchdog; frame position resyncs on frame_start
  always @(posedge pclk) begin
    logic [1:0] e;
    cyc++;
    if (cyc > 70000) begin
      n_mismatch++;
      wrap_up();
    end
    if (hdlc_take === 1'b1) n_take++;
    if (presetn && out_valid === 1'b1 && out_ready === 1'b1) begin
      if (out_word.frame_start === 1'b1) begin
        if (!settle && n_frames > 0) `CHECK("frame length", 256, pos)
        if (!cfg_busy) settle = 1'b0;
        n_frames++;
        frm = (out_word.mf_start === 1'b1) ? 0 : frm + 1;
        pos = 0;
      end
      e = exp_bit(pos, frm);
      if (!settle && e[1]) begin
        `CHECK("line", e[0], out_word.data)
      end
      // Reference CRC over the sent bits, C slots as zero, used in the next sub-multiframe
      m_crc = {m_crc[2:0], 1'b0}
        ^ ((m_crc[3] ^ (out_word.data && !(pos == 0 && frm % 2 == 0))) ? 4'h3 : 4'h0);
      if (pos == 255 && frm % 8 == 7) begin
        m_hold = m_crc;
        m_crc = 4'h0;
      end
      pos++;
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    chk_reg(e1_ovh_pkg::SYNC_MUX_IDX, e1_ovh_pkg::SYNC_MUX_RST);
    chk_reg(e1_ovh_pkg::TX_SIG_DL_IDX, e1_ovh_pkg::TX_SIG_DL_RST);
    chk_reg(e1_ovh_pkg::FRAMING_CTRL_IDX, e1_ovh_pkg::FRAMING_CTRL_RST);
    chk_reg(e1_ovh_pkg::NAT_SELECT_IDX, e1_ovh_pkg::NAT_SELECT_RST);
    chk_reg(e1_ovh_pkg::NAT_VALUE_IDX, e1_ovh_pkg::NAT_VALUE_RST);
    apb(1'b0, 12'h000, 32'h0, rd, err);
    `CHECK("unmapped pslverr", 1'b1, err)
    `CHECK("unmapped data", 32'h0, rd)
    wr(e1_ovh_pkg::TX_SIG_DL_IDX, 8'hf8);
    chk_reg(e1_ovh_pkg::TX_SIG_DL_IDX, 8'hf8);
    wr(e1_ovh_pkg::TX_SIG_DL_IDX, 8'h00);
    // Internal framing, then serial E bits, external alignment, external CRC; national bits forced high
    run_frames(8);
    cfg(8'h40, 8'h00, 8'h01, 8'h00, 8'hf8);
    run_frames(9);
    cfg(8'h01, 8'h00, 8'h01, 8'h00, 8'hf8);
    run_frames(2);
    cfg(8'h02, 8'h00, 8'h01, 8'h00, 8'hf8);
    run_frames(2);
    cfg(8'h02, 8'h00, 8'h00, 8'h00, 8'hf8);
    run_frames(2);
    // Data link on three bits, register value on two
    cfg(8'h04, 8'hf8, 8'h01, 8'h28, 8'h20);
    n_take = 0;
    run_frames(2);
    `CHECK("hdlc_take seen", 1'b1, n_take != 0)
    cfg(8'h00, 8'hf8, 8'h01, 8'h00, 8'hf8);
    run_frames(2);
    // Receiver stall: buffer fills, framing holds, nothing lost
    out_ready <= 1'b0;
    repeat (40) @(posedge pclk);
    apb(1'b0, {e1_ovh_pkg::STATUS_IDX, 2'b00}, 32'h0, st, err);
    repeat (20) @(posedge pclk);
    apb(1'b0, {e1_ovh_pkg::STATUS_IDX, 2'b00}, 32'h0, rd, err);
    `CHECK("buffer count", 2'h2, st[17:16])
    `CHECK("held bit position", st[7:0], rd[7:0])
    `CHECK("out_valid", 1'b1, out_valid)
    out_ready <= 1'b1;
    run_frames(2);
    wrap_up();
  end
endmodule // test_e1_tx_overhead_source_select

`default_nettype wire
